// ==== pkg/scp_pkg.sv ====
// constants and types shared by both ends of the serial command port
// assumes both ends compile this package first
package scp_pkg;
    localparam int          SCP_NUM_REGS    = 9;
    localparam int          SCP_TIMEOUT_LOG = 18;
    localparam logic [3:0]  SCP_OP_READ     = 4'h2;
    localparam logic [3:0]  SCP_OP_WRITE    = 4'h4;
    localparam logic [6:0]  SCP_OP_RESET    = 7'h03;
    localparam logic [2:0]  SCP_BIT_LAST    = 3'h7;
    localparam logic [7:0]  SCP_ID_BITS     = 8'h00; // arbitrary id value
    // default contents: mode/gain register and N register nonzero
    localparam logic [7:0]  SCP_DEF_0       = 8'h18;
    localparam logic [7:0]  SCP_DEF_3       = 8'h07;
    localparam logic [7:0]  SCP_DEF_OTHER   = 8'h00;
    localparam int          SCP_HOST_DIV    = 4; // mclk cycles per sclk half period
    typedef enum logic [3:0] {
        SCP_ST_OPC1 = 4'b0001,
        SCP_ST_OPC2 = 4'b0010,
        SCP_ST_WDAT = 4'b0100,
        SCP_ST_RDAT = 4'b1000
    } scp_state_type;
    typedef enum logic [3:0] {
        SCP_H_IDLE  = 4'b0001,
        SCP_H_LOW   = 4'b0010,
        SCP_H_HIGH  = 4'b0100,
        SCP_H_DONE  = 4'b1000
    } scp_host_type;
endpackage

// ==== pkg/scp_if.sv ====
// serial link between host and device: chip select, clock, data in, data out
// dout resolves here from its enable, reading high while undriven
interface scp_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout_o;
    logic dout_oe;
    logic dout;
    assign dout = dout_oe ? dout_o : 1'b1;
    modport device (input cs_n, input sclk, input din, output dout_o, output dout_oe);
    modport host   (output cs_n, output sclk, output din, input dout);
endinterface

// ==== hdl/scp_device.sv ====
// device end: command decoder and register file on sclk, timeout on mclk
// assumes sclk from host; mclk free running; reset_powerdown_n asynchronous pin
module scp_device
    import scp_pkg::*;
#(
    parameter int TIMEOUT_LOG = SCP_TIMEOUT_LOG
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        reset_powerdown_n,
    scp_if.device            link,
    output logic [7:0]       reg_view [SCP_NUM_REGS],
    output logic             port_busy
);
    initial begin
        if (TIMEOUT_LOG < 2 || TIMEOUT_LOG > 30) $error("bad TIMEOUT_LOG");
    end

    // mclk side: synchronise sclk, cs and pin
    logic       sclk_s1_r, sclk_s2_r, cs_s1_r, cs_s2_r, pin_s1_r, pin_s2_r;
    logic [TIMEOUT_LOG-1:0] tmo_cnt_r, tmo_cnt_nxt;
    logic       tmo_rst_r, tmo_rst_nxt;
    logic       pin_rst_r, pin_rst_nxt;

    // timeout counts only while sclk sits low, fires once per interval
    always_comb begin
        tmo_cnt_nxt = '0;
        tmo_rst_nxt = 1'b0;
        pin_rst_nxt = rst | ~pin_s2_r;
        if (!sclk_s2_r) begin
            tmo_cnt_nxt = tmo_cnt_r + 1'b1;
            tmo_rst_nxt = &tmo_cnt_r;
        end
    end
    always_ff @(posedge mclk) begin
        sclk_s1_r <= link.sclk;
        sclk_s2_r <= sclk_s1_r;
        cs_s1_r   <= link.cs_n;
        cs_s2_r   <= cs_s1_r;
        pin_s1_r  <= reset_powerdown_n;
        pin_s2_r  <= pin_s1_r;
        if (rst) begin
            tmo_cnt_r <= '0;
            tmo_rst_r <= 1'b0;
            pin_rst_r <= 1'b1;
        end else begin
            tmo_cnt_r <= tmo_cnt_nxt;
            tmo_rst_r <= tmo_rst_nxt;
            pin_rst_r <= pin_rst_nxt;
        end
    end
    assign port_busy = ~cs_s2_r;

    // port resets reach the sclk side asynchronously, as sclk stands low then;
    // a host that starts a frame right at the timeout instant races it
    logic dev_rst, port_arst;
    assign dev_rst   = pin_rst_r;
    assign port_arst = link.cs_n | pin_rst_r | tmo_rst_r;

    // decoder state on sclk
    scp_state_type st_r, st_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [6:0] sh_r, sh_nxt;
    logic [3:0] ptr_r, ptr_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic       rd_r, rd_nxt;
    logic [7:0] regs_r [SCP_NUM_REGS];
    logic [7:0] regs_nxt [SCP_NUM_REGS];
    logic       soft_rst;
    logic [7:0] byte_in;

    assign byte_in = {sh_r, link.din};
    always_comb begin
        st_nxt   = st_r;
        bit_nxt  = bit_r + 1'b1;
        sh_nxt   = {sh_r[5:0], link.din};
        ptr_nxt  = ptr_r;
        cnt_nxt  = cnt_r;
        rd_nxt   = rd_r;
        soft_rst = 1'b0;
        regs_nxt = regs_r;
        if (bit_r == SCP_BIT_LAST) begin
            unique case (st_r)
                SCP_ST_OPC1: begin
                    ptr_nxt = byte_in[3:0];
                    if (byte_in[7:4] == SCP_OP_READ) begin
                        rd_nxt = 1'b1;
                        st_nxt = SCP_ST_OPC2;
                    end else if (byte_in[7:4] == SCP_OP_WRITE) begin
                        rd_nxt = 1'b0;
                        st_nxt = SCP_ST_OPC2;
                    end else if (byte_in[7:1] == SCP_OP_RESET) begin
                        soft_rst = 1'b1;
                    end
                end
                SCP_ST_OPC2: begin
                    cnt_nxt = byte_in[3:0];
                    st_nxt  = rd_r ? SCP_ST_RDAT : SCP_ST_WDAT;
                end
                SCP_ST_WDAT: begin
                    for (int i = 0; i < SCP_NUM_REGS; i++) begin
                        if (ptr_r == 4'(i)) regs_nxt[i] = byte_in;
                    end
                    regs_nxt[0][7:5] = SCP_ID_BITS[7:5];
                    if (ptr_r != 4'hF) ptr_nxt = ptr_r + 1'b1;
                    cnt_nxt = cnt_r - 1'b1;
                    if (cnt_r == 4'h0) st_nxt = SCP_ST_OPC1;
                end
                SCP_ST_RDAT: begin
                    if (ptr_r != 4'hF) ptr_nxt = ptr_r + 1'b1;
                    cnt_nxt = cnt_r - 1'b1;
                    if (cnt_r == 4'h0) st_nxt = SCP_ST_OPC1;
                end
                default: st_nxt = SCP_ST_OPC1;
            endcase
        end
    end

    // any port reset acts asynchronously, as the sclk may stand still
    always_ff @(posedge link.sclk or posedge port_arst) begin
        if (port_arst) begin
            st_r  <= SCP_ST_OPC1;
            bit_r <= '0;
            sh_r  <= '0;
            ptr_r <= '0;
            cnt_r <= '0;
            rd_r  <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            bit_r <= bit_nxt;
            sh_r  <= sh_nxt;
            ptr_r <= ptr_nxt;
            cnt_r <= cnt_nxt;
            rd_r  <= rd_nxt;
        end
    end

    // register file, reloaded by any device reset
    always_ff @(posedge link.sclk or posedge dev_rst) begin
        if (dev_rst) begin
            for (int i = 0; i < SCP_NUM_REGS; i++) begin
                regs_r[i] <= (i == 0) ? SCP_DEF_0 : (i == 3) ? SCP_DEF_3 : SCP_DEF_OTHER;
            end
        end else begin
            for (int i = 0; i < SCP_NUM_REGS; i++) begin
                if (soft_rst) begin
                    regs_r[i] <= (i == 0) ? SCP_DEF_0 : (i == 3) ? SCP_DEF_3 : SCP_DEF_OTHER;
                end else if (!link.cs_n) begin
                    regs_r[i] <= regs_nxt[i];
                end
            end
        end
    end
    assign reg_view = regs_r;

    // output shifter on falling sclk; loads on fall with bit 0 of a read byte
    logic [7:0] rbyte;
    logic [7:0] osh_r;
    always_comb begin
        rbyte = 8'h00;
        for (int i = 0; i < SCP_NUM_REGS; i++) begin
            if (ptr_r == 4'(i)) rbyte = regs_r[i];
        end
    end
    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            osh_r <= 8'h00;
        end else if (st_r == SCP_ST_RDAT && bit_r == 3'h0) begin
            osh_r <= rbyte;
        end else begin
            osh_r <= {osh_r[6:0], 1'b0};
        end
    end
    assign link.dout_o  = osh_r[7];
    assign link.dout_oe = ~link.cs_n;
endmodule

// ==== hdl/scp_host.sv ====
// host end: sends one command per request, divides mclk into sclk
// assumes the user holds req data stable until done
module scp_host
    import scp_pkg::*;
#(
    parameter int DIV = SCP_HOST_DIV
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    scp_if.host              link,
    input  wire logic        req,
    input  wire logic [4:0]  nbytes,
    input  wire logic [7:0]  tx_bytes [18],
    output logic             busy,
    output logic             done,
    output logic [7:0]       rx_bytes [18]
);
    initial begin
        if (DIV < 1 || DIV > 255) $error("bad DIV");
    end
    logic          din_s1_r, din_s2_r;
    scp_host_type  st_r, st_nxt;
    logic [7:0]    div_r, div_nxt;
    logic [7:0]    bit_r, bit_nxt;
    logic [7:0]    rx_r [18];
    logic [7:0]    rx_nxt [18];
    logic          total_last;

    // link data synchronised before use
    always_ff @(posedge mclk) begin
        din_s1_r <= link.dout;
        din_s2_r <= din_s1_r;
    end
    assign total_last = (bit_r == {nbytes, 3'h7});
    always_comb begin
        st_nxt  = st_r;
        div_nxt = div_r + 1'b1;
        bit_nxt = bit_r;
        rx_nxt  = rx_r;
        unique case (st_r)
            SCP_H_IDLE: begin
                div_nxt = '0;
                bit_nxt = '0;
                if (req) st_nxt = SCP_H_LOW;
            end
            SCP_H_LOW: if (div_r == 8'(DIV - 1)) begin
                div_nxt = '0;
                st_nxt  = SCP_H_HIGH;
            end
            SCP_H_HIGH: if (div_r == 8'(DIV - 1)) begin
                div_nxt = '0;
                // sample late in the high phase, after the fall-launched bit settles
                rx_nxt[bit_r[7:3]][3'h7 - bit_r[2:0]] = din_s2_r;
                bit_nxt = bit_r + 1'b1;
                st_nxt  = total_last ? SCP_H_DONE : SCP_H_LOW;
            end
            SCP_H_DONE: st_nxt = SCP_H_IDLE;
            default:    st_nxt = SCP_H_IDLE;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r  <= SCP_H_IDLE;
            div_r <= '0;
            bit_r <= '0;
            for (int i = 0; i < 18; i++) rx_r[i] <= 8'h00;
        end else begin
            st_r  <= st_nxt;
            div_r <= div_nxt;
            bit_r <= bit_nxt;
            rx_r  <= rx_nxt;
        end
    end
    // sclk idles low; host sends short commands well inside the timeout
    assign link.sclk = (st_r == SCP_H_HIGH);
    assign link.cs_n = (st_r == SCP_H_IDLE) || (st_r == SCP_H_DONE);
    assign link.din  = tx_bytes[bit_r[7:3]][3'h7 - bit_r[2:0]];
    assign busy      = (st_r != SCP_H_IDLE);
    assign done      = (st_r == SCP_H_DONE);
    assign rx_bytes  = rx_r;
endmodule

// ==== testbench/scp_properties.sv ====
// checker for the serial link between host and device ends
// assumes mclk oversamples sclk (host divides mclk by 8 per bit)
module scp_properties
    import scp_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout_o,
    input wire logic dout_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       sclk_q;
    logic [7:0] bit_cnt_r;
    logic [7:0] op_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // count sclk rises within a frame, keep the first byte
    always_ff @(posedge mclk) begin
        sclk_q <= sclk;
        if (rst || cs_n) begin
            bit_cnt_r <= 8'h00;
        end else if (sclk && !sclk_q) begin
            bit_cnt_r <= bit_cnt_r + 8'h01;
            if (bit_cnt_r < 8'h08) begin
                op_r <= {op_r[6:0], din};
            end
        end
    end
    sequence s_bit_high;
        sclk [*4] ##1 !sclk;
    endsequence
    sequence s_lead_low;
        !sclk [*4];
    endsequence
    chk_cs_tristate: assert property (cs_n && $past(cs_n) |-> !dout_oe)
        else $error("dout driven while deselected");
    chk_frame_bytes: assert property ($rose(cs_n) |-> bit_cnt_r[2:0] == 3'h0)
        else $error("frame not whole bytes");
    chk_din_stable: assert property ($rose(sclk) |-> $stable(din))
        else $error("din moved at sclk rise");
    chk_dout_launch: assert property ($changed(dout_o) && dout_oe && $past(dout_oe)
        |-> $fell(sclk))
        else $error("dout moved away from sclk fall");
    chk_bit_period: assert property ($rose(sclk) |-> s_bit_high)
        else $error("sclk high phase wrong");
    chk_frame_start: assert property ($fell(cs_n) |-> s_lead_low)
        else $error("sclk rose too soon after select");
    chk_frame_end: assert property ($rose(cs_n) |-> !sclk)
        else $error("deselect while sclk high");
    chk_read_drive: assert property (!cs_n && !$past(cs_n) && $changed(dout_o)
        |-> bit_cnt_r >= 8'h10 && op_r[7:4] == SCP_OP_READ)
        else $error("dout moved outside read data");
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench: host end drives the device end over the link
// assumes design compiled with scp_pkg and scp_if
module tb_top
    import scp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk, rst, reset_powerdown_n, req, busy, done, port_busy;
    logic [4:0] nbytes;
    logic [7:0] tx [18];
    logic [7:0] rx [18];
    logic [7:0] reg_view [SCP_NUM_REGS];
    int         num_errors = 0;
    int         checks = 0;
    int         i;
    scp_if link_if ();
    scp_device #(.TIMEOUT_LOG(6)) u_scp_device (.mclk(mclk), .rst(rst),
        .reset_powerdown_n(reset_powerdown_n), .link(link_if.device),
        .reg_view(reg_view), .port_busy(port_busy));
    scp_host u_scp_host (.mclk(mclk), .rst(rst), .link(link_if.host), .req(req),
        .nbytes(nbytes), .tx_bytes(tx), .busy(busy), .done(done), .rx_bytes(rx));
    scp_properties u_scp_properties (.mclk(mclk), .rst(rst), .cs_n(link_if.cs_n),
        .sclk(link_if.sclk), .din(link_if.din), .dout_o(link_if.dout_o),
        .dout_oe(link_if.dout_oe));
    // free running master clock
    always #5 mclk = ~mclk;
    // register contents expected after any reset
    function automatic logic [7:0] dv(input int k);
        if (k == 0) return (SCP_DEF_0 & 8'h1F) | (SCP_ID_BITS & 8'hE0);
        return (k == 3) ? SCP_DEF_3 : SCP_DEF_OTHER;
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one command frame, pad extra zero bytes for read data
    task automatic send(input logic [7:0] q[$], input int pad);
        int k;
        for (k = 0; k < 18; k++) tx[k] = (k < q.size()) ? q[k] : 8'h00;
        nbytes = 5'(q.size() + pad - 1);
        req = 1'b1;
        k = 0;
        while (busy !== 1'b1 && k < 100) begin
            @(negedge mclk);
            k++;
        end
        req = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 3000) begin
            @(negedge mclk);
            k++;
        end
        if (k >= 3000) num_errors++;
        repeat (8) @(negedge mclk);
    endtask
    // pin low while a frame runs, which the device must ignore, then release
    task automatic pin_reset();
        reset_powerdown_n = 1'b0;
        send('{8'h00}, 0);
        reset_powerdown_n = 1'b1;
        repeat (4) @(negedge mclk);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #400000;
        num_errors++;
        close_out();
    end
    // test sequence
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        reset_powerdown_n = 1'b1;
        req = 1'b0;
        nbytes = 5'h00;
        foreach (tx[k]) tx[k] = 8'h00;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        pin_reset();
        send('{8'h06}, 0);
        send('{8'h20, 8'h08}, 9);
        for (i = 0; i < 9; i++) begin
            chk("read default", dv(i), rx[i + 2]);
            chk("view default", dv(i), reg_view[i]);
        end
        chk("port idle", 8'h00, {7'h00, port_busy});
        $display("test defaults done");
        send('{8'h47, 8'h02, 8'hA5, 8'h5A, 8'hC3}, 0);
        chk("write reg7", 8'hA5, reg_view[7]);
        chk("write reg8", 8'h5A, reg_view[8]);
        chk("reg6 kept", dv(6), reg_view[6]);
        // idle with sclk low past the timeout; the port must still answer after
        repeat (100) @(negedge mclk);
        send('{8'h27, 8'h03}, 4);
        chk("read reg7", 8'hA5, rx[2]);
        chk("read reg8", 8'h5A, rx[3]);
        chk("read past end", 8'h00, rx[4]);
        chk("read past end", 8'h00, rx[5]);
        $display("test burst done");
        send('{8'h07}, 0);
        chk("cmd reset reg7", dv(7), reg_view[7]);
        chk("cmd reset reg8", dv(8), reg_view[8]);
        $display("test command reset done");
        send('{8'h40, 8'h01, 8'hFF, 8'h3C}, 0);
        chk("id bits kept", (SCP_ID_BITS & 8'hE0) | 8'h1F, reg_view[0]);
        chk("write reg1", 8'h3C, reg_view[1]);
        pin_reset();
        chk("pin reset reg0", dv(0), reg_view[0]);
        chk("pin reset reg1", dv(1), reg_view[1]);
        $display("test pin reset done");
        send('{8'h41, 8'h00}, 0);
        send('{8'h42, 8'h00, 8'h77}, 0);
        chk("fresh frame reg2", 8'h77, reg_view[2]);
        chk("cut frame reg1", dv(1), reg_view[1]);
        $display("test deselect done");
        close_out();
    end
endmodule
